// File: chcr_defs.svh
// offsets, field positions, reset values and timing figures of the bank
`ifndef CHCR_DEFS_SVH
`define CHCR_DEFS_SVH

`define CHCR_OFS_VOLT 8'h04
`define CHCR_OFS_TIMER 8'h05
`define CHCR_OFS_INPUT 8'h06
`define CHCR_OFS_BSW 8'h07

`define CHCR_RST_VOLT 8'h58
`define CHCR_RST_TIMER 8'h9f
`define CHCR_RST_INPUT 8'he6
`define CHCR_RST_BSW 8'h4c
// detect_battery_switch_ctrl bits that the watchdog returns to default
`define CHCR_WDOG_MASK_BSW 8'hd4

`define CHCR_VOLT_CODE_MAX 5'h18
`define CHCR_VOLT_BASE_UV 3848000
`define CHCR_VOLT_STEP_UV 32000

`define CHCR_BIT_RECHG 0
`define CHCR_BIT_TIMER_EN 3
`define CHCR_BIT_TIMEOUT 2
`define CHCR_BIT_DETECT 7
`define CHCR_BIT_SLOW 6
`define CHCR_BIT_BSW_DIS 5
`define CHCR_BIT_WARM 4
`define CHCR_BIT_BSW_DLY 3
`define CHCR_BIT_BSW_RST 2

`define CHCR_VIN_BASE_MV 14'd3900
`define CHCR_VIN_STEP_MV 14'd100
`define CHCR_TRACK_1_MV 14'd200
`define CHCR_TRACK_2_MV 14'd250
`define CHCR_TRACK_3_MV 14'd300

`define CHCR_CLK_HZ 100000000
`define CHCR_TOPOFF_STEP_S 16'd900
`define CHCR_SAFETY_SHORT_S 16'd18000
`define CHCR_SAFETY_LONG_S 16'd36000
`define CHCR_BSW_DELAY_S 16'd10

`endif

// File: chcr_pkg.sv
// types shared by the charger configuration bank
package chcr_pkg;
  typedef enum logic [2:0] {
    CHCR_TOF_IDLE = 3'b001,
    CHCR_TOF_RUN = 3'b010,
    CHCR_TOF_DONE = 3'b100
  } chcr_tof_state_t;
  typedef enum logic [2:0] {
    CHCR_BSW_ON = 3'b001,
    CHCR_BSW_WAIT = 3'b010,
    CHCR_BSW_OFF = 3'b100
  } chcr_bsw_state_t;
endpackage

// File: chcr_regs.sv
// configuration registers 0x04..0x07 of the charger with their timers
`timescale 1ns/1ps
`default_nettype none
`include "chcr_defs.svh"

module chcr_regs
  import chcr_pkg::*;
#(
  parameter longint unsigned SEC_CYCLES = `CHCR_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rst,
  input wire logic wdog_expire,
  input wire logic vbus_present,
  input wire logic detect_done,
  input wire logic charging,
  input wire logic term_met,
  input wire logic in_limiting,
  input wire logic in_cool,
  input wire logic in_thermal,
  input wire logic in_warm,
  input wire logic [12:0] vbat_mv,
  output logic [7:0] reg_rdata_reg,
  output logic [4:0] charge_voltage_target_reg,
  output logic warm_cap_reg,
  output logic recharge_threshold_sel_reg,
  output logic [1:0] input_overvoltage_sel_reg,
  output logic [1:0] boost_output_sel_reg,
  output logic [13:0] vin_limit_mv_reg,
  output logic detect_req_reg,
  output logic topoff_active_reg,
  output logic charge_done_reg,
  output logic safety_expired_reg,
  output logic battery_switch_on_reg,
  output logic battery_switch_reset_enable_reg
);
  localparam logic [26:0] SEC_LAST = 27'(SEC_CYCLES - 1);
  // output flops other than reg_rdata_reg and vin_limit_mv_reg (reset to zero) come out of reset showing the register defaults
  localparam logic [7:0] RST_VOLT = `CHCR_RST_VOLT;
  localparam logic [7:0] RST_INPUT = `CHCR_RST_INPUT;
  localparam logic [7:0] RST_BSW = `CHCR_RST_BSW;

  logic [7:0] volt_reg, timer_reg, input_reg, bsw_reg;
  logic [7:0] volt_next, timer_next, input_next, bsw_next;
  logic [26:0] pre_reg;
  logic sec_tick_reg, half_reg;
  logic [15:0] tof_cnt_reg, safe_cnt_reg, bsw_cnt_reg;
  chcr_tof_state_t tof_reg, tof_next;
  chcr_bsw_state_t bsw_st_reg, bsw_st_next;

  // ---------------- register writes
  wire wr_volt = reg_wr && reg_addr == `CHCR_OFS_VOLT;
  wire wr_timer = reg_wr && reg_addr == `CHCR_OFS_TIMER;
  wire wr_input = reg_wr && reg_addr == `CHCR_OFS_INPUT;
  wire wr_bsw = reg_wr && reg_addr == `CHCR_OFS_BSW;
  wire [4:0] volt_code_w = (reg_wdata[7:3] > `CHCR_VOLT_CODE_MAX) ?
                           `CHCR_VOLT_CODE_MAX : reg_wdata[7:3];
  // detection end clears the trigger; a host write in the same cycle wins
  wire [7:0] bsw_after_done = detect_done ?
      (bsw_reg & ~(8'h01 << `CHCR_BIT_DETECT)) : bsw_reg;
  wire [7:0] bsw_wdog = (bsw_reg & ~`CHCR_WDOG_MASK_BSW) |
                        (`CHCR_RST_BSW & `CHCR_WDOG_MASK_BSW);

  // register reset beats a write, a write beats watchdog expiry
  assign volt_next = reg_rst ? `CHCR_RST_VOLT :
                     wr_volt ? {volt_code_w, reg_wdata[2:0]} :
                     wdog_expire ? `CHCR_RST_VOLT : volt_reg;
  assign timer_next = reg_rst ? `CHCR_RST_TIMER :
                      wr_timer ? reg_wdata :
                      wdog_expire ? `CHCR_RST_TIMER : timer_reg;
  assign input_next = reg_rst ? `CHCR_RST_INPUT :
                      wr_input ? reg_wdata : input_reg;
  assign bsw_next = reg_rst ? `CHCR_RST_BSW :
                    wr_bsw ? reg_wdata :
                    wdog_expire ? bsw_wdog : bsw_after_done;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_reg <= `CHCR_RST_VOLT;
      timer_reg <= `CHCR_RST_TIMER;
      input_reg <= `CHCR_RST_INPUT;
      bsw_reg <= `CHCR_RST_BSW;
    end else begin
      volt_reg <= volt_next;
      timer_reg <= timer_next;
      input_reg <= input_next;
      bsw_reg <= bsw_next;
    end
  end

  // unmapped offsets read as zero
  wire [7:0] rd_sel = (reg_addr == `CHCR_OFS_VOLT) ? volt_reg :
                      (reg_addr == `CHCR_OFS_TIMER) ? timer_reg :
                      (reg_addr == `CHCR_OFS_INPUT) ? input_reg :
                      (reg_addr == `CHCR_OFS_BSW) ? bsw_reg : 8'h00;

  // ---------------- one-second time base shared by all timers
  wire pre_wrap = pre_reg == SEC_LAST;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= 27'h0;
      sec_tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_wrap ? 27'h0 : pre_reg + 27'h1;
      sec_tick_reg <= pre_wrap;
    end
  end

  // ---------------- top-off extension
  wire [1:0] tof_code = volt_reg[2:1];
  wire [15:0] tof_limit = 16'(`CHCR_TOPOFF_STEP_S * tof_code);
  wire tof_end = sec_tick_reg && (tof_cnt_reg + 16'h1 >= tof_limit);

  always_comb begin
    tof_next = tof_reg;
    case (tof_reg)
      CHCR_TOF_IDLE: begin
        if (charging && term_met) begin
          // no extension: terminate on the spot
          tof_next = (tof_code == 2'b00) ? CHCR_TOF_DONE :
                     CHCR_TOF_RUN;
        end
      end
      CHCR_TOF_RUN: begin
        if (!charging) begin
          tof_next = CHCR_TOF_IDLE;
        end else if (tof_end) begin
          tof_next = CHCR_TOF_DONE;
        end
      end
      CHCR_TOF_DONE: begin
        if (!charging) begin
          tof_next = CHCR_TOF_IDLE;
        end
      end
      default: tof_next = CHCR_TOF_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tof_reg <= CHCR_TOF_IDLE;
      tof_cnt_reg <= 16'h0;
    end else begin
      tof_reg <= tof_next;
      if (tof_reg != CHCR_TOF_RUN) begin
        tof_cnt_reg <= 16'h0;
      end else if (sec_tick_reg) begin
        tof_cnt_reg <= tof_cnt_reg + 16'h1;
      end
    end
  end

  // ---------------- safety timer
  wire timer_en = timer_reg[`CHCR_BIT_TIMER_EN];
  wire [15:0] safe_limit = timer_reg[`CHCR_BIT_TIMEOUT] ?
      `CHCR_SAFETY_LONG_S : `CHCR_SAFETY_SHORT_S;
  wire slow = bsw_reg[`CHCR_BIT_SLOW] &&
              (in_limiting || in_cool || in_thermal);
  // when slowed only every second tick counts
  wire safe_step = sec_tick_reg && (!slow || half_reg);
  wire safe_run = charging && timer_en;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      safe_cnt_reg <= 16'h0;
      half_reg <= 1'b0;
      safety_expired_reg <= 1'b0;
    end else begin
      if (sec_tick_reg) begin
        half_reg <= ~half_reg;
      end
      if (!safe_run) begin
        safe_cnt_reg <= 16'h0;
        safety_expired_reg <= 1'b0;
      end else if (safe_step && !safety_expired_reg) begin
        safe_cnt_reg <= safe_cnt_reg + 16'h1;
        safety_expired_reg <= (safe_cnt_reg + 16'h1 >= safe_limit);
      end
    end
  end

  // ---------------- battery switch control
  wire bsw_dis = bsw_reg[`CHCR_BIT_BSW_DIS];
  always_comb begin
    bsw_st_next = bsw_st_reg;
    case (bsw_st_reg)
      CHCR_BSW_ON: begin
        if (bsw_dis) begin
          bsw_st_next = bsw_reg[`CHCR_BIT_BSW_DLY] ? CHCR_BSW_WAIT :
                        CHCR_BSW_OFF;
        end
      end
      CHCR_BSW_WAIT: begin
        if (!bsw_dis) begin
          bsw_st_next = CHCR_BSW_ON;
        end else if (sec_tick_reg &&
                     bsw_cnt_reg + 16'h1 >= `CHCR_BSW_DELAY_S) begin
          bsw_st_next = CHCR_BSW_OFF;
        end
      end
      CHCR_BSW_OFF: begin
        if (!bsw_dis) begin
          bsw_st_next = CHCR_BSW_ON;
        end
      end
      default: bsw_st_next = CHCR_BSW_ON;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bsw_st_reg <= CHCR_BSW_ON;
      bsw_cnt_reg <= 16'h0;
    end else begin
      bsw_st_reg <= bsw_st_next;
      if (bsw_st_reg != CHCR_BSW_WAIT) begin
        bsw_cnt_reg <= 16'h0;
      end else if (sec_tick_reg) begin
        bsw_cnt_reg <= bsw_cnt_reg + 16'h1;
      end
    end
  end

  // ---------------- input voltage limit with battery tracking
  wire [13:0] vin_reg_mv = `CHCR_VIN_BASE_MV +
      14'(`CHCR_VIN_STEP_MV * input_reg[3:0]);
  wire [13:0] track_ofs = (bsw_reg[1:0] == 2'b01) ? `CHCR_TRACK_1_MV :
                          (bsw_reg[1:0] == 2'b10) ? `CHCR_TRACK_2_MV :
                          `CHCR_TRACK_3_MV;
  wire [13:0] track_mv = {1'b0, vbat_mv} + track_ofs;
  // tracking can only raise the limit, never drop it below the register
  wire [13:0] vin_eff = (bsw_reg[1:0] != 2'b00 && track_mv > vin_reg_mv) ?
                        track_mv : vin_reg_mv;

  // ---------------- output flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_reg <= 8'h00;
      charge_voltage_target_reg <= RST_VOLT[7:3];
      warm_cap_reg <= 1'b0;
      recharge_threshold_sel_reg <= 1'b0;
      input_overvoltage_sel_reg <= RST_INPUT[7:6];
      boost_output_sel_reg <= RST_INPUT[5:4];
      vin_limit_mv_reg <= 14'h0;
      detect_req_reg <= 1'b0;
      topoff_active_reg <= 1'b0;
      charge_done_reg <= 1'b0;
      battery_switch_on_reg <= 1'b1;
      battery_switch_reset_enable_reg <= RST_BSW[`CHCR_BIT_BSW_RST];
    end else begin
      reg_rdata_reg <= rd_sel;
      charge_voltage_target_reg <= volt_reg[7:3];
      warm_cap_reg <= in_warm && !bsw_reg[`CHCR_BIT_WARM];
      recharge_threshold_sel_reg <= volt_reg[`CHCR_BIT_RECHG];
      input_overvoltage_sel_reg <= input_reg[7:6];
      boost_output_sel_reg <= input_reg[5:4];
      vin_limit_mv_reg <= vin_eff;
      detect_req_reg <= bsw_reg[`CHCR_BIT_DETECT] && vbus_present;
      topoff_active_reg <= tof_next == CHCR_TOF_RUN;
      charge_done_reg <= tof_next == CHCR_TOF_DONE;
      battery_switch_on_reg <= bsw_st_next != CHCR_BSW_OFF;
      battery_switch_reset_enable_reg <= bsw_reg[`CHCR_BIT_BSW_RST];
    end
  end

  // ---------------- checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  volt_clamp_a: assert property (
    reg_wr && reg_addr == `CHCR_OFS_VOLT && !reg_rst
    |=> volt_reg[7:3] <= `CHCR_VOLT_CODE_MAX)
    else $error("charge voltage code above clamp");
  volt_reset_a: assert property (
    reg_rst |=> volt_reg == `CHCR_RST_VOLT ##1
    charge_voltage_target_reg == RST_VOLT[7:3])
    else $error("charge voltage default wrong");
  no_ext_done_a: assert property (
    tof_reg == CHCR_TOF_IDLE && charging && term_met && tof_code == 2'b00
    |-> ##1 charge_done_reg && !topoff_active_reg)
    else $error("no extension must end charge at once");
  timer_off_a: assert property (
    !timer_reg[`CHCR_BIT_TIMER_EN] |=> !safety_expired_reg)
    else $error("safety timer runs while disabled");
  slow_hold_a: assert property (
    safe_run && slow && !half_reg && sec_tick_reg
    |=> $stable(safe_cnt_reg))
    else $error("slowed timer counted on skipped tick");
  sequence dis_set_s;
    bsw_st_reg == CHCR_BSW_ON && bsw_dis && !bsw_reg[`CHCR_BIT_BSW_DLY];
  endsequence
  sequence off_now_s;
    ##2 !battery_switch_on_reg;
  endsequence
  switch_now_a: assert property (dis_set_s |-> off_now_s)
    else $error("switch not off right away");
  switch_allow_a: assert property (
    !bsw_dis |=> battery_switch_on_reg)
    else $error("switch not allowed on");
  delay_hold_a: assert property (
    bsw_st_reg == CHCR_BSW_WAIT && bsw_cnt_reg + 16'h1 < `CHCR_BSW_DELAY_S
    |=> battery_switch_on_reg)
    else $error("switch went off before the delay");
  expire_late_a: assert property (
    safe_run && !safety_expired_reg && safe_cnt_reg + 16'h1 < safe_limit
    |=> !safety_expired_reg)
    else $error("safety timer expired early");
  detect_gate_a: assert property (
    !vbus_present |=> !detect_req_reg)
    else $error("detection requested without supply");
  detect_clear_a: assert property (
    detect_done && !reg_wr && !reg_rst && !wdog_expire
    |=> !bsw_reg[`CHCR_BIT_DETECT])
    else $error("detect trigger not cleared");
  wdog_keep_a: assert property (
    wdog_expire && !reg_rst && !reg_wr |=> $stable(input_reg) &&
    ((bsw_reg ^ $past(bsw_reg)) & ~`CHCR_WDOG_MASK_BSW) == 8'h00)
    else $error("watchdog touched kept fields");
  track_min_a: assert property (
    arst_n |=> vin_limit_mv_reg >= $past(vin_reg_mv))
    else $error("input limit below register value");
  warm_cap_a: assert property (
    in_warm && !bsw_reg[`CHCR_BIT_WARM] |=> warm_cap_reg)
    else $error("warm cap missing");
endmodule
`default_nettype wire

// File: chcr_detect_model.sv
// far-side model of the input detection engine
`timescale 1ns/1ps
`default_nettype none
module chcr_detect_model #(
  parameter int LAG = 6
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic detect_req_reg,
  output logic detect_done
);
  int cnt;
  // a done pulse after LAG cycles of request, repeated every LAG + 5 cycles while it stays up; the lag stands in for the detection time
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      detect_done <= 1'b0;
    end else begin
      detect_done <= detect_req_reg && cnt == LAG;
      cnt <= (detect_req_reg && cnt < LAG + 4) ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the charger configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, arst_n, reg_wr, reg_rst, wdog_expire, vbus_present;
  logic detect_done, charging, term_met, in_limiting, in_cool, in_thermal;
  logic in_warm, watch, warm_cap, rech, det_req, tof_act, done, expired;
  logic sw_on, sw_rst;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic [12:0] vbat_mv;
  logic [4:0] target;
  logic [1:0] input_overvoltage_sel, boost;
  logic [13:0] vin;
  int error_cnt, compares, sel;
  int offs [4] = '{0, 200, 250, 300};
  assign watch = sel == 1 ? done : sel == 2 ? !sw_on : expired;
  // one tick per cycle keeps the hour-long timers inside the run
  chcr_regs #(.SEC_CYCLES(1)) dut (.core_clk(core_clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rst(reg_rst), .wdog_expire(wdog_expire),
    .vbus_present(vbus_present), .detect_done(detect_done),
    .charging(charging), .term_met(term_met), .in_limiting(in_limiting),
    .in_cool(in_cool), .in_thermal(in_thermal), .in_warm(in_warm),
    .vbat_mv(vbat_mv), .reg_rdata_reg(rdata),
    .charge_voltage_target_reg(target), .warm_cap_reg(warm_cap),
    .recharge_threshold_sel_reg(rech), .input_overvoltage_sel_reg(input_overvoltage_sel),
    .boost_output_sel_reg(boost), .vin_limit_mv_reg(vin),
    .detect_req_reg(det_req), .topoff_active_reg(tof_act),
    .charge_done_reg(done), .safety_expired_reg(expired),
    .battery_switch_on_reg(sw_on), .battery_switch_reset_enable_reg(sw_rst));
  chcr_detect_model #(.LAG(6)) host_det (.core_clk(core_clk),
    .arst_n(arst_n), .detect_req_reg(det_req), .detect_done(detect_done));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    cyc(2);
    chk(rdata, e);
  endtask
  task automatic pulse(input int which);
    @(posedge core_clk);
    if (which == 0) wdog_expire <= 1'b1;
    else reg_rst <= 1'b1;
    @(posedge core_clk);
    wdog_expire <= 1'b0;
    reg_rst <= 1'b0;
  endtask
  // waits for the watched flag: quiet for lo cycles, then up within hi
  task automatic win(input int s, input int lo, input int hi);
    int n;
    sel = s;
    cyc(lo);
    chk(watch, 0);
    n = lo;
    while (watch !== 1'b1 && n < hi) begin
      cyc(1);
      n++;
    end
    chk(watch, 1);
  endtask
  task automatic set_chg(input logic c, input logic t);
    @(posedge core_clk);
    charging <= c;
    term_met <= t;
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    {arst_n, reg_wr, reg_rst, wdog_expire, vbus_present, charging} = '0;
    {term_met, in_limiting, in_cool, in_thermal, in_warm} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    vbat_mv = 13'h0fa0;
    sel = 0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    cyc(3);
    chk(vin, 14'h1194);
    chk(target, 16'h000b);
    chk(sw_rst, 1);
    rd(8'h04, 8'h58);
    rd(8'h05, 8'h9f);
    rd(8'h06, 8'he6);
    rd(8'h07, 8'h4c);
    rd(8'h08, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hc7);
    chk(target, 16'h0018);
    wr(8'h04, 8'ha1);
    rd(8'h04, 8'ha1);
    chk(rech, 1);
    for (int c = 0; c < 4; c++) begin
      wr(8'h06, {c[1:0], c[1:0], 4'hf});
      cyc(3);
      chk(input_overvoltage_sel, c);
      chk(boost, c);
      chk(vin, 14'd5400);
    end
    wr(8'h06, 8'h00);
    for (int t = 0; t < 4; t++) begin
      wr(8'h07, 8'h4c | t);
      cyc(3);
      chk(vin, t == 0 ? 3900 : 4000 + offs[t]);
    end
    wr(8'h06, 8'h0f);
    cyc(3);
    chk(vin, 14'd5400);
    in_warm <= 1'b1;
    wr(8'h07, 8'h5c);
    cyc(3);
    chk(warm_cap, 0);
    wr(8'h07, 8'h4c);
    cyc(3);
    chk(warm_cap, 1);
    wr(8'h07, 8'h48);
    cyc(3);
    chk(sw_rst, 0);
    wr(8'h07, 8'h64);
    win(2, 0, 4);
    wr(8'h07, 8'h4c);
    cyc(4);
    chk(sw_on, 1);
    wr(8'h07, 8'h6c);
    win(2, 7, 16);
    wr(8'h07, 8'h4c);
    wr(8'h07, 8'hcc);
    cyc(3);
    chk(det_req, 0);
    @(posedge core_clk);
    vbus_present <= 1'b1;
    cyc(3);
    chk(det_req, 1);
    cyc(12);
    rd(8'h07, 8'h4c);
    chk(det_req, 0);
    wr(8'h04, 8'h58);
    set_chg(1'b1, 1'b1);
    cyc(3);
    chk(done, 1);
    chk(tof_act, 0);
    set_chg(1'b0, 1'b0);
    wr(8'h04, 8'h5a);
    set_chg(1'b1, 1'b1);
    cyc(3);
    chk(tof_act, 1);
    win(1, 880, 930);
    set_chg(1'b0, 1'b0);
    wr(8'h05, 8'hb3);
    set_chg(1'b1, 1'b0);
    cyc(18010);
    chk(expired, 0);
    set_chg(1'b0, 1'b0);
    wr(8'h05, 8'hbb);
    set_chg(1'b1, 1'b0);
    win(0, 17980, 18030);
    set_chg(1'b0, 1'b0);
    in_cool <= 1'b1;
    set_chg(1'b1, 1'b0);
    win(0, 35970, 36040);
    set_chg(1'b0, 1'b0);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h5f);
    pulse(0);
    rd(8'h04, 8'h58);
    rd(8'h05, 8'h9f);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h4f);
    pulse(1);
    rd(8'h06, 8'he6);
    rd(8'h07, 8'h4c);
    end_of_test;
  end
endmodule
`default_nettype wire
